/* verilog/cps_pkg.sv */
// constants and types shared by the card power serial control block
package cps_pkg;

    // ==========================================================
    // serial word layout
    localparam int WORD_W        = 11;
    localparam int BIT_PROG_A_HI = 0;
    localparam int BIT_PROG_A_LO = 1;
    localparam int BIT_CORE_A_LO = 2;
    localparam int BIT_CORE_A_HI = 3;
    localparam int BIT_PROG_B_HI = 4;
    localparam int BIT_PROG_B_LO = 5;
    localparam int BIT_CORE_B_HI = 6;
    localparam int BIT_CORE_B_LO = 7;
    localparam int BIT_ON        = 8;
    localparam int BIT_PROG_A_X  = 9;
    localparam int BIT_PROG_B_X  = 10;

    localparam logic [WORD_W-1:0] WORD_RST = 11'h000;

    // ==========================================================
    // bit counter
    localparam int                CNT_W   = 4;
    localparam logic [CNT_W-1:0]  CNT_RST = 4'h0;
    localparam logic [CNT_W-1:0]  CNT_MAX = 4'hF;
    localparam logic [CNT_W-1:0]  CNT_FULL = 4'hB;

    // ==========================================================
    // register map and layouts
    localparam int                ADDR_W     = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STAT  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_EVT   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_HOLD  = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_SHIFT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_SEL   = 8'h14;
    localparam int                EVT_W      = 3;
    localparam int                EVT_FAULT  = 0;
    localparam int                EVT_IGNORE = 1;
    localparam int                EVT_LEN    = 2;
    localparam logic [EVT_W-1:0]  EVT_RST    = 3'h0;
    localparam logic [31:0]       RDATA_RST  = 32'h0000_0000;

    // ==========================================================
    // per-output supply selection
    typedef enum logic [2:0] {SUP_GND, SUP_HIZ, SUP_3V3, SUP_5V, SUP_12V} cps_supply_t;

endpackage

/* verilog/cps_dec_if.sv */
// carrier between the top and the word decoder
`timescale 1ns/1ns
`default_nettype none
interface cps_dec_if;
    import cps_pkg::*;
    logic [WORD_W-1:0] word;
    logic              independent;
    logic              grounded;
    cps_supply_t       core_a;
    cps_supply_t       prog_a;
    cps_supply_t       core_b;
    cps_supply_t       prog_b;

    modport decoder (input word, input independent, input grounded,
                     output core_a, output prog_a, output core_b, output prog_b);
    modport owner   (output word, output independent, output grounded,
                     input core_a, input prog_a, input core_b, input prog_b);
endinterface
`default_nettype wire

/* verilog/cps_sync.sv */
// two-flop synchroniser with rising edge detection
`timescale 1ns/1ns
`default_nettype none
module cps_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    // pins
    input  wire logic [W-1:0] i_async,
    // synchronised view
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;
    logic [1:0]   warm_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    // counts the two cycles the chain needs to hold real pin samples
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            warm_ff <= 2'h0;
        end else begin
            warm_ff <= {warm_ff[0], 1'b1};
        end
    end

    // edge detection stays blind until the chain is warm, so a pin already
    // high at reset release makes no false edge
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !warm_ff[1]) begin
            prev_ff <= '1;
        end else begin
            prev_ff <= sync_ff;
        end
    end

    assign o_level = sync_ff;
    assign o_rise  = sync_ff & ~prev_ff;
endmodule
`default_nettype wire

/* verilog/cps_decoder.sv */
// decodes the holding word into four supply selections
`timescale 1ns/1ns
`default_nettype none
module cps_decoder
    import cps_pkg::*;
(
    cps_dec_if.decoder dec
);
    function automatic cps_supply_t core_sel(input logic hi, input logic lo);
        case ({hi, lo})
            2'h1:    core_sel = SUP_3V3;
            2'h2:    core_sel = SUP_5V;
            default: core_sel = SUP_GND;
        endcase
    endfunction

    function automatic cps_supply_t prog_sel(input logic hi, input logic lo, input logic x,
                                             input logic indep, input cps_supply_t core);
        case ({hi, lo})
            2'h0:    prog_sel = SUP_GND;
            2'h1:    prog_sel = indep ? (x ? SUP_5V : SUP_3V3) : core;
            2'h2:    prog_sel = SUP_12V;
            default: prog_sel = SUP_HIZ;
        endcase
    endfunction

    always_comb begin
        cps_supply_t ca;
        cps_supply_t cb;
        ca = core_sel(dec.word[BIT_CORE_A_HI], dec.word[BIT_CORE_A_LO]);
        cb = core_sel(dec.word[BIT_CORE_B_HI], dec.word[BIT_CORE_B_LO]);
        if (dec.grounded) begin
            dec.core_a = SUP_GND;
            dec.prog_a = SUP_GND;
            dec.core_b = SUP_GND;
            dec.prog_b = SUP_GND;
        end else if (!dec.word[BIT_ON]) begin
            dec.core_a = SUP_HIZ;
            dec.prog_a = SUP_HIZ;
            dec.core_b = SUP_HIZ;
            dec.prog_b = SUP_HIZ;
        end else begin
            dec.core_a = ca;
            dec.core_b = cb;
            dec.prog_a = prog_sel(dec.word[BIT_PROG_A_HI], dec.word[BIT_PROG_A_LO],
                                  dec.word[BIT_PROG_A_X], dec.independent, ca);
            dec.prog_b = prog_sel(dec.word[BIT_PROG_B_HI], dec.word[BIT_PROG_B_LO],
                                  dec.word[BIT_PROG_B_X], dec.independent, cb);
        end
    end
endmodule
`default_nettype wire

/* verilog/cps_top.sv */
// card power serial control: serial word capture, reset handling, outputs, registers
`timescale 1ns/1ns
`default_nettype none
module cps_top
    import cps_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    // serial link
    input  wire logic              i_serial_clk,
    input  wire logic              i_serial_data,
    input  wire logic              i_load_strobe,
    // reset and mode pins
    input  wire logic              i_reset_hi,
    input  wire logic              i_reset_n,
    input  wire logic              i_mode,
    // fault sensing
    input  wire logic [3:0]        i_overcurrent,
    input  wire logic              i_overtemp,
    // register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    // supply outputs
    output cps_supply_t            o_slot_a_core_supply,
    output cps_supply_t            o_slot_a_program_supply,
    output cps_supply_t            o_slot_b_core_supply,
    output cps_supply_t            o_slot_b_program_supply,
    output logic                   o_discharge_switch_one,
    output logic                   o_discharge_switch_two,
    output logic                   o_discharge_switch_three,
    output logic                   o_discharge_switch_four,
    output logic                   o_fault_flag_n
);
    // ==========================================================
    // pin synchronisation
    localparam int PIN_W = 11;

    logic [PIN_W-1:0] pin_level;
    logic [PIN_W-1:0] pin_rise;

    cps_sync #(.W(PIN_W)) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_overtemp, i_overcurrent, i_mode, i_reset_n, i_reset_hi,
                     i_load_strobe, i_serial_data, i_serial_clk}),
        .o_level   (pin_level),
        .o_rise    (pin_rise)
    );

    logic       sclk_rise;
    logic       sdata;
    logic       load_rise;
    logic       rst_pin;
    logic       mode_hi;
    logic       fault_live;

    assign sclk_rise  = pin_rise[0];
    assign sdata      = pin_level[1];
    assign load_rise  = pin_rise[2];
    assign mode_hi    = pin_level[5];
    assign fault_live = |pin_level[10:6];

    // ==========================================================
    // control register
    logic ctrl_discharge_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl_discharge_ff <= 1'b0;
        end else if (i_wr && i_addr == ADDR_CTRL) begin
            ctrl_discharge_ff <= i_wdata[0];
        end
    end

    // the active-low pin reads zero while synchronising, so it resets conservatively
    assign rst_pin = pin_level[3] | ~pin_level[4] | ctrl_discharge_ff;

    // ==========================================================
    // shift register and bit count
    logic [WORD_W-1:0] shift_ff;
    logic [CNT_W-1:0]  count_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            shift_ff <= WORD_RST;
        end else if (sclk_rise) begin
            shift_ff <= {shift_ff[WORD_W-2:0], sdata};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            count_ff <= CNT_RST;
        end else if (load_rise) begin
            count_ff <= CNT_RST;
        end else if (sclk_rise && count_ff != CNT_MAX) begin
            count_ff <= count_ff + 4'h1;
        end
    end

    // ==========================================================
    // holding register and grounded state
    logic [WORD_W-1:0] hold_ff;
    logic              grounded_ff;
    logic              take_load;

    // relies on the controller to leave a clock edge clear of the strobe edge
    assign take_load = load_rise && !rst_pin;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            hold_ff <= WORD_RST;
        end else if (take_load) begin
            hold_ff <= shift_ff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            grounded_ff <= 1'b1;
        end else if (rst_pin) begin
            grounded_ff <= 1'b1;
        end else if (take_load) begin
            grounded_ff <= 1'b0;
        end
    end

    // ==========================================================
    // decode and registered outputs
    cps_dec_if dec ();

    assign dec.word        = hold_ff;
    assign dec.independent = mode_hi;
    assign dec.grounded    = grounded_ff | rst_pin;

    cps_decoder u_dec (
        .dec (dec.decoder)
    );

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_slot_a_core_supply    <= SUP_GND;
            o_slot_a_program_supply <= SUP_GND;
            o_slot_b_core_supply    <= SUP_GND;
            o_slot_b_program_supply <= SUP_GND;
        end else begin
            o_slot_a_core_supply    <= dec.core_a;
            o_slot_a_program_supply <= dec.prog_a;
            o_slot_b_core_supply    <= dec.core_b;
            o_slot_b_program_supply <= dec.prog_b;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_discharge_switch_one   <= 1'b1;
            o_discharge_switch_two   <= 1'b1;
            o_discharge_switch_three <= 1'b1;
            o_discharge_switch_four  <= 1'b1;
        end else begin
            o_discharge_switch_one   <= dec.core_a == SUP_GND;
            o_discharge_switch_two   <= dec.prog_a == SUP_GND;
            o_discharge_switch_three <= dec.core_b == SUP_GND;
            o_discharge_switch_four  <= dec.prog_b == SUP_GND;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_fault_flag_n <= 1'b1;
        end else begin
            o_fault_flag_n <= ~fault_live;
        end
    end

    // ==========================================================
    // sticky events, write one to clear, a new event wins
    logic [EVT_W-1:0] evt_ff;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;

    always_comb begin
        evt_set             = EVT_RST;
        evt_set[EVT_FAULT]  = fault_live;
        evt_set[EVT_IGNORE] = load_rise && rst_pin;
        evt_set[EVT_LEN]    = take_load && count_ff != CNT_FULL;
        evt_clr             = (i_wr && i_addr == ADDR_EVT) ? i_wdata[EVT_W-1:0] : EVT_RST;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            evt_ff <= EVT_RST;
        end else begin
            evt_ff <= (evt_ff & ~evt_clr) | evt_set;
        end
    end

    // ==========================================================
    // read port, data valid only in the cycle after the strobe
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = RDATA_RST;
        if (i_addr == ADDR_CTRL) begin
            rd_mux = {31'h0000_0000, ctrl_discharge_ff};
        end else if (i_addr == ADDR_STAT) begin
            rd_mux = {24'h00_0000, count_ff, mode_hi, fault_live, rst_pin, grounded_ff};
        end else if (i_addr == ADDR_EVT) begin
            rd_mux = {29'h0000_0000, evt_ff};
        end else if (i_addr == ADDR_HOLD) begin
            rd_mux = {21'h00_0000, hold_ff};
        end else if (i_addr == ADDR_SHIFT) begin
            rd_mux = {21'h00_0000, shift_ff};
        end else if (i_addr == ADDR_SEL) begin
            rd_mux = {20'h0_0000, o_slot_b_program_supply, o_slot_b_core_supply,
                      o_slot_a_program_supply, o_slot_a_core_supply};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= RDATA_RST;
        end else if (i_rd) begin
            o_rdata <= rd_mux;
        end else begin
            o_rdata <= RDATA_RST;
        end
    end
endmodule
`default_nettype wire

/* verification/cps_link_model.sv */
// card socket controller model driving the serial link
`timescale 1ns/1ns
`default_nettype none
module cps_link_model (
    // clock
    input  wire logic i_clk,
    // serial link
    output logic      o_serial_clk,
    output logic      o_serial_data,
    output logic      o_load_strobe
);
    initial begin
        o_serial_clk = 1'b0;
        o_serial_data = 1'b0;
        o_load_strobe = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic pulse_load();
        o_load_strobe <= 1'b1;
        wait_clk(4);
        o_load_strobe <= 1'b0;
        wait_clk(1);
    endtask

    // msb first; serial clock stands low between frames
    task automatic send(input logic [10:0] w, input logic load);
        for (int i = 10; i >= 0; i--) begin
            o_serial_data <= w[i];
            wait_clk(3);
            o_serial_clk <= 1'b1;
            wait_clk(4);
            o_serial_clk <= 1'b0;
            wait_clk(1);
        end
        // released data line shows the inverse of its last bit
        o_serial_data <= ~w[0];
        if (load) begin
            pulse_load();
        end
    endtask
endmodule
`default_nettype wire

/* verification/cps_checker.sv */
// assertion checker for the card power serial control block
`timescale 1ns/1ns
`default_nettype none
module cps_checker
    import cps_pkg::*;
(
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    // pins
    input wire logic        i_load_strobe,
    input wire logic        i_reset_hi,
    input wire logic        i_reset_n,
    input wire logic        i_mode,
    input wire logic        i_wr,
    input wire logic [3:0]  i_overcurrent,
    input wire logic        i_overtemp,
    // outputs
    input wire cps_supply_t o_slot_a_core_supply,
    input wire cps_supply_t o_slot_a_program_supply,
    input wire cps_supply_t o_slot_b_core_supply,
    input wire cps_supply_t o_slot_b_program_supply,
    input wire logic        o_discharge_switch_one,
    input wire logic        o_discharge_switch_four,
    input wire logic        o_fault_flag_n
);
    wire logic [11:0] sel = {o_slot_b_program_supply, o_slot_b_core_supply,
                             o_slot_a_program_supply, o_slot_a_core_supply};
    wire logic        all_gnd = (sel == 12'h000);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // ==========================================================
    // assertions
    property p_dis_one; o_discharge_switch_one == (o_slot_a_core_supply == SUP_GND); endproperty
    a_dis_one: assert property (p_dis_one)
        else $error("discharge one disagrees with core A");
    property p_dis_four;
        o_discharge_switch_four == (o_slot_b_program_supply == SUP_GND);
    endproperty
    a_dis_four: assert property (p_dis_four)
        else $error("discharge four disagrees with prog B");
    property p_rst_hi; i_reset_hi [*4] |-> all_gnd; endproperty
    a_rst_hi: assert property (p_rst_hi)
        else $error("outputs not grounded in high reset");
    property p_rst_n; (!i_reset_n) [*4] |-> all_gnd; endproperty
    a_rst_n: assert property (p_rst_n)
        else $error("outputs not grounded in low reset");
    property p_hold;
        (!i_load_strobe && !i_wr && !i_reset_hi && i_reset_n && $stable(i_mode)) [*6]
            |=> $stable(sel);
    endproperty
    a_hold: assert property (p_hold)
        else $error("outputs changed without a load");
    property p_fault; (|i_overcurrent || i_overtemp) [*4] |-> !o_fault_flag_n; endproperty
    a_fault: assert property (p_fault)
        else $error("fault flag not raised");
    property p_nofault; (!(|i_overcurrent) && !i_overtemp) [*4] |-> o_fault_flag_n; endproperty
    a_nofault: assert property (p_nofault)
        else $error("fault flag raised without cause");
    property p_off; o_slot_a_core_supply == SUP_HIZ |-> sel == {4{SUP_HIZ}}; endproperty
    a_off: assert property (p_off)
        else $error("shutdown not applied to all outputs");
    property p_legacy;
        (!i_mode) [*4] ##0 (o_slot_a_program_supply inside {SUP_3V3, SUP_5V})
            |-> o_slot_a_program_supply == o_slot_a_core_supply;
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy prog A does not follow core A");
endmodule

bind cps_top cps_checker u_chk (.i_clk, .i_sys_rst, .i_load_strobe, .i_reset_hi, .i_reset_n,
    .i_mode, .i_wr, .i_overcurrent, .i_overtemp, .o_slot_a_core_supply,
    .o_slot_a_program_supply, .o_slot_b_core_supply, .o_slot_b_program_supply,
    .o_discharge_switch_one, .o_discharge_switch_four, .o_fault_flag_n);
`default_nettype wire

/* verification/tb_card_power_serial_control.sv */
// testbench for the card power serial control block
`timescale 1ns/1ns
`default_nettype none
module tb_card_power_serial_control;
    import cps_pkg::*;
    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              reset_hi = 1'b0;
    logic              reset_n = 1'b1;
    logic              mode = 1'b1;
    logic [3:0]        overcurrent = 4'h0;
    logic              overtemp = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [31:0]       wdata = 32'h0000_0000;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [31:0]       rdata;
    logic              sclk;
    logic              sdata;
    logic              strobe;
    cps_supply_t       ca;
    cps_supply_t       pa;
    cps_supply_t       cb;
    cps_supply_t       pb;
    logic [3:0]        dis;
    logic              fault_n;
    logic [10:0]       w;
    logic [10:0]       w2;
    int                err_count = 0;
    int                check_count = 0;

    always #25 clk = ~clk;

    cps_link_model u_link (.i_clk(clk), .o_serial_clk(sclk), .o_serial_data(sdata),
        .o_load_strobe(strobe));
    cps_top u_dut (.i_clk(clk), .i_sys_rst(sys_rst), .i_serial_clk(sclk),
        .i_serial_data(sdata), .i_load_strobe(strobe), .i_reset_hi(reset_hi),
        .i_reset_n(reset_n), .i_mode(mode), .i_overcurrent(overcurrent),
        .i_overtemp(overtemp), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_slot_a_core_supply(ca), .o_slot_a_program_supply(pa),
        .o_slot_b_core_supply(cb), .o_slot_b_program_supply(pb),
        .o_discharge_switch_one(dis[0]), .o_discharge_switch_two(dis[1]),
        .o_discharge_switch_three(dis[2]), .o_discharge_switch_four(dis[3]),
        .o_fault_flag_n(fault_n));

    // ==========================================================
    // helpers
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [2:0] core_of(input logic [1:0] c);
        return (c == 2'h1) ? SUP_3V3 : (c == 2'h2) ? SUP_5V : SUP_GND;
    endfunction

    function automatic logic [2:0] prog_of(input logic [1:0] c, input logic x,
                                           input logic [2:0] core);
        case (c)
            2'h0: return SUP_GND;
            2'h1: return mode ? (x ? SUP_5V : SUP_3V3) : core;
            2'h2: return SUP_12V;
            default: return SUP_HIZ;
        endcase
    endfunction

    function automatic logic [10:0] mk(input logic [1:0] c_a, p_a, c_b, p_b,
                                       input logic x_a, x_b, on);
        return {x_b, x_a, on, c_b[0], c_b[1], p_b[0], p_b[1], c_a[1], c_a[0], p_a[0], p_a[1]};
    endfunction

    task automatic chk_sup(input logic [10:0] v, input logic grounded);
        logic [2:0]  e_ca;
        logic [2:0]  e_cb;
        logic [11:0] e;
        e_ca = core_of({v[3], v[2]});
        e_cb = core_of({v[6], v[7]});
        e = {prog_of({v[4], v[5]}, v[10], e_cb), e_cb, prog_of({v[0], v[1]}, v[9], e_ca), e_ca};
        if (!v[8]) e = {4{SUP_HIZ}};
        if (grounded) e = 12'h000;
        chk({pb, cb, pa, ca}, e);
        chk(dis, {e[11:9] == SUP_GND, e[8:6] == SUP_GND, e[5:3] == SUP_GND, e[2:0] == SUP_GND});
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
        @(posedge clk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        #2_000_000;
        err_count++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk_sup(11'h000, 1'b1);
        chk(fault_n, 1'b1);
        for (int m = 1; m >= 0; m--) begin
            mode <= m[0];
            for (int i = 0; i < 8; i++) begin
                w = mk(i[1:0], i[1:0], ~i[1:0], i[1:0] + 2'h1, i[2], ~i[2], 1'b1);
                u_link.send(w, 1'b1);
                repeat (6) @(posedge clk);
                chk_sup(w, 1'b0);
            end
        end
        w = mk(2'h1, 2'h1, 2'h2, 2'h2, 1'b0, 1'b0, 1'b0);
        u_link.send(w, 1'b1);
        repeat (6) @(posedge clk);
        chk_sup(w, 1'b0);
        w2 = mk(2'h2, 2'h2, 2'h1, 2'h3, 1'b1, 1'b0, 1'b1);
        u_link.send(w2, 1'b0);
        repeat (6) @(posedge clk);
        chk_sup(w, 1'b0);
        u_link.pulse_load();
        repeat (6) @(posedge clk);
        chk_sup(w2, 1'b0);
        w = mk(2'h1, 2'h2, 2'h2, 2'h0, 1'b0, 1'b1, 1'b1);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) reset_hi <= 1'b1;
            else reset_n <= 1'b0;
            repeat (5) @(posedge clk);
            chk_sup(w2, 1'b1);
            u_link.send(~w, 1'b1);
            reset_hi <= 1'b0;
            reset_n <= 1'b1;
            repeat (8) @(posedge clk);
            chk_sup(w, 1'b1);
            reg_rd(ADDR_HOLD, {21'h00_0000, w2});
            u_link.send(w, 1'b1);
            repeat (6) @(posedge clk);
            chk_sup(w, 1'b0);
            w2 = w;
        end
        for (int f = 0; f < 5; f++) begin
            {overtemp, overcurrent} <= 5'h01 << f;
            repeat (5) @(posedge clk);
            chk(fault_n, 1'b0);
            {overtemp, overcurrent} <= 5'h00;
            repeat (5) @(posedge clk);
            chk(fault_n, 1'b1);
        end
        reg_wr(ADDR_CTRL, 32'h0000_0001);
        repeat (5) @(posedge clk);
        chk_sup(w, 1'b1);
        reg_rd(ADDR_CTRL, 32'h0000_0001);
        reg_rd(ADDR_STAT, 32'h0000_0003);
        reg_rd(ADDR_SHIFT, {21'h00_0000, w});
        reg_rd(ADDR_EVT, 32'h0000_0003);
        reg_wr(ADDR_EVT, 32'h0000_0007);
        reg_rd(ADDR_EVT, 32'h0000_0000);
        reg_wr(ADDR_HOLD, 32'h0000_0000);
        reg_rd(ADDR_HOLD, {21'h000000, w});
        reg_rd(8'h20, 32'h0000_0000);
        reg_wr(ADDR_CTRL, 32'h0000_0000);
        repeat (5) @(posedge clk);
        chk_sup(w, 1'b1);
        u_link.send(w, 1'b1);
        repeat (6) @(posedge clk);
        chk_sup(w, 1'b0);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk_sup(w, 1'b1);
        reg_rd(ADDR_HOLD, 32'h0000_0000);
        stop_test();
    end
endmodule
`default_nettype wire
